// ==== hdl/fpc_host.sv ====
// Host-side controller that programs a parallel NOR flash through its pins.
// Software drives a simple strobe port; the flash is wired to the pin ports.
//
// Contract
// [R01] Host writes with select and strobe low, enable high.
// [R02] Device latches address on falling, data on rising.
// [R03] Device returns to read mode after programming.
// [R04] Programming only clears bits; erase sets them.
// [R05] Device ignores commands during an operation.
// [R06] No autoselect or query while programming.
// [R07] Hardware reset ends operation; host repeats sequence.
// [R08] Single programs allowed anywhere, any order.
// [R09] Single program: three command writes, then data.
// [R10] Buffer holds at most 32 words.
// [R11] Buffer program: unlock twice, load at sector.
// [R12] Load command 25h, confirm 29h at sector.
// [R13] Host writes count minus one at sector.
// [R14] Device aborts on count above capacity.
// [R15] First load fixes page; rest stay inside.
// [R16] Device aborts on wrong sector or page.
// [R17] Every load decrements the count, last wins.
// [R18] Confirm follows the loads; anything else aborts.
// [R19] Host polls status at last loaded location.
// [R20] Buffer program suspendable; read mode after success.
// [R21] Abort shows abort bit, toggling, timeout low.
// [R22] Host recovers bypass aborts with abort reset.
// [R23] Abort reset: two unlocks, then F0h.
// [R24] Repeated buffer programs allowed without erase.
// [R25] Device restarts decode on any mismatched write.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_host
	import fpc_pkg::*;
#(
	parameter bit          BYTE_MODE = 1'b0,
	parameter int unsigned POLL_MAX  = `FPC_POLL_MAX
) (
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	input  wire logic [7:0]             reg_addr,
	input  wire logic [31:0]            reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [31:0]            reg_rdata,
	output logic      [`FPC_ADDR_W-1:0] flash_addr,
	input  wire logic [`FPC_DATA_W-1:0] flash_dq_in,
	output logic      [`FPC_DATA_W-1:0] flash_dq_out,
	output logic                        flash_dq_oe,
	output logic                        flash_chip_select_n,
	output logic                        flash_write_strobe_n,
	output logic                        flash_output_enable_n,
	output logic                        flash_reset_n
);

	typedef enum {S_IDLE, S_FETCH, S_ISSUE, S_WAIT, S_RD_ISSUE, S_RD_WAIT,
	              S_RST_PULSE, S_RST_WAIT} fpc_state_t;

	fpc_state_t             state;
	fpc_op_t                op;
	logic [`FPC_ADDR_W-1:0] target_addr;
	logic [`FPC_DATA_W-1:0] single_data;
	logic [7:0]             word_count;
	logic [`FPC_BUF_IDX_W-1:0] buf_wr_idx;
	logic [7:0]             step;
	logic [15:0]            timer;
	logic                   first_read;
	logic [`FPC_DATA_W-1:0] prev_read;
	logic [`FPC_DATA_W-1:0] poll_word;
	logic                   st_done;
	logic                   st_abort;
	logic                   st_fail;
	logic                   cg_done;
	logic [`FPC_DATA_W-1:0] cg_rdata;
	logic [`FPC_DATA_W-1:0] buf_rdata;
	fpc_pins_t              pins;

	localparam logic [`FPC_ADDR_W-1:0] UNL1 = BYTE_MODE ? `FPC_UNL1_BYTE : `FPC_UNL1_WORD;
	localparam logic [`FPC_ADDR_W-1:0] UNL2 = BYTE_MODE ? `FPC_UNL2_BYTE : `FPC_UNL2_WORD;
	localparam logic [15:0] POLL_LIMIT = 16'(POLL_MAX);
	localparam logic [15:0] RP_LAST    = 16'(`FPC_RP_CYC - 1);
	localparam logic [15:0] RH_LAST    = 16'(`FPC_RH_CYC - 1);

	// Picks the address and data of one step of a command sequence.
	function automatic fpc_cycle_t seq_cycle(
		input fpc_op_t                sel_op,
		input logic [7:0]             idx,
		input logic [`FPC_ADDR_W-1:0] addr,
		input logic [`FPC_DATA_W-1:0] data,
		input logic [7:0]             count,
		input logic [`FPC_DATA_W-1:0] buf_word
	);
		fpc_cycle_t c;
		c = '{addr: addr, data: data};
		if (idx == 8'h00) begin
			c = '{addr: UNL1, data: `FPC_CMD_UNL1};
		end else if (idx == 8'h01) begin
			c = '{addr: UNL2, data: `FPC_CMD_UNL2};
		end else if (sel_op == FPC_OP_SINGLE) begin
			// Setup command, then the word itself at any address. [R09] [R08]
			c = (idx == 8'h02) ? '{addr: UNL1, data: `FPC_CMD_PROG} : '{addr: addr, data: data};
		end else if (sel_op == FPC_OP_ABORT_RESET) begin
			c = '{addr: UNL1, data: `FPC_CMD_RESET}; // [R23] [R22]
		end else if (idx == 8'h02) begin
			c = '{addr: addr, data: `FPC_CMD_BUFLOAD}; // [R11] [R12]
		end else if (idx == 8'h03) begin
			c = '{addr: addr, data: `FPC_DATA_W'(count)}; // [R13]
		end else if (idx < count + 8'h05) begin
			// Consecutive words from the target keep one page when software aligns them. [R15]
			c = '{addr: addr + `FPC_ADDR_W'(idx - 8'h04), data: buf_word}; // [R17]
		end else begin
			c = '{addr: addr, data: `FPC_CMD_CONFIRM}; // [R18] [R12]
		end
		return c;
	endfunction

	wire fpc_cycle_t cur_cycle = seq_cycle(op, step, target_addr, single_data,
	                                        word_count, buf_rdata);

	wire logic [7:0] last_step = (op == FPC_OP_SINGLE) ? 8'h03 :
	                             (op == FPC_OP_ABORT_RESET) ? 8'h02 :
	                             word_count + 8'h05;

	// Status is read at the last location written, which for a buffer is the last load. [R19]
	wire logic [`FPC_ADDR_W-1:0] poll_addr = (op == FPC_OP_BUFFER) ?
	                                         target_addr + `FPC_ADDR_W'(word_count) :
	                                         target_addr;

	wire logic [`FPC_BUF_IDX_W-1:0] buf_rd_idx = `FPC_BUF_IDX_W'(step - 8'h04);
	wire logic busy       = (state != S_IDLE);
	wire logic ctrl_wr    = reg_wr && (reg_addr == `FPC_REG_CTRL);
	wire logic start_cmd  = ctrl_wr && !busy;
	wire logic buf_wr     = reg_wr && !busy && (reg_addr == `FPC_REG_BUF);
	wire logic cg_start   = (state == S_ISSUE) || (state == S_RD_ISSUE);
	wire logic cg_is_read = (state == S_RD_ISSUE);
	wire fpc_cycle_t cg_cycle = cg_is_read ? '{addr: poll_addr, data: '0} : cur_cycle;

	wire logic toggling   = prev_read[`FPC_DQ_TOGGLE] != cg_rdata[`FPC_DQ_TOGGLE];
	// Error bits count only on two reads in a row; one read may already be plain data.
	wire logic seen_abort = toggling && prev_read[`FPC_DQ_ABORT] && cg_rdata[`FPC_DQ_ABORT];
	wire logic seen_tmo   = toggling && prev_read[`FPC_DQ_TIMEOUT] && cg_rdata[`FPC_DQ_TIMEOUT];
	wire logic poll_over  = (timer == POLL_LIMIT);

	wire logic [31:0] status_word = {28'h0000000, st_fail, st_abort, st_done, busy};

	fpc_buf_mem #(
		.WIDTH (`FPC_DATA_W),
		.DEPTH (`FPC_BUF_DEPTH),
		.IDX_W (`FPC_BUF_IDX_W)
	) u_buf (
		.clock   (clock),
		.wr_en   (buf_wr),
		.wr_idx  (buf_wr_idx),
		.wr_data (reg_wdata[`FPC_DATA_W-1:0]),
		.rd_idx  (buf_rd_idx),
		.rd_data (buf_rdata)
	);

	fpc_cycle_gen u_cycle (
		.clock      (clock),
		.rst_n      (rst_n),
		.start      (cg_start),
		.is_read    (cg_is_read),
		.cycle      (cg_cycle),
		.hold_reset (state == S_RST_PULSE),
		.dq_in      (flash_dq_in),
		.done       (cg_done),
		.rd_data    (cg_rdata),
		.pins       (pins)
	);

	assign flash_addr            = pins.addr;
	assign flash_dq_out          = pins.dq_out;
	assign flash_dq_oe           = pins.dq_oe;
	assign flash_chip_select_n   = pins.chip_select_n;
	assign flash_write_strobe_n  = pins.write_strobe_n;
	assign flash_output_enable_n = pins.output_enable_n;
	assign flash_reset_n         = pins.reset_n;

	// Software registers; a count write rewinds the buffer fill index.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			target_addr <= '0;
			single_data <= '0;
			word_count  <= 8'h00;
			buf_wr_idx  <= '0;
		end else if (reg_wr && !busy) begin
			case (reg_addr)
				`FPC_REG_ADDR:  target_addr <= reg_wdata[`FPC_ADDR_W-1:0];
				`FPC_REG_DATA:  single_data <= reg_wdata[`FPC_DATA_W-1:0];
				`FPC_REG_COUNT: begin
					// Not clipped: a count past the buffer reaches the flash as written. [R14]
					word_count <= reg_wdata[7:0];
					buf_wr_idx <= '0;
				end
				`FPC_REG_BUF:   buf_wr_idx <= buf_wr_idx + 1'b1; // [R10]
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`FPC_REG_CTRL:   reg_rdata <= {30'h00000000, op};
				`FPC_REG_ADDR:   reg_rdata <= 32'(target_addr);
				`FPC_REG_DATA:   reg_rdata <= 32'(single_data);
				`FPC_REG_COUNT:  reg_rdata <= {24'h000000, word_count};
				`FPC_REG_STATUS: reg_rdata <= status_word;
				`FPC_REG_POLL:   reg_rdata <= 32'(poll_word);
				default:         reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Sequencer. Commands from software are refused while busy, so nothing but
	// status reads reaches the flash during an embedded operation. [R05] [R06]
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state      <= S_IDLE;
			op         <= FPC_OP_SINGLE;
			step       <= 8'h00;
			timer      <= 16'h0000;
			first_read <= 1'b1;
			prev_read  <= '0;
			poll_word  <= '0;
			st_done    <= 1'b0;
			st_abort   <= 1'b0;
			st_fail    <= 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
					if (start_cmd) begin
						op       <= fpc_op_t'(reg_wdata[`FPC_CTRL_OP_MSB:`FPC_CTRL_OP_LSB]);
						step     <= 8'h00;
						timer    <= 16'h0000;
						st_done  <= 1'b0;
						st_abort <= 1'b0;
						st_fail  <= 1'b0;
						state    <= (fpc_op_t'(reg_wdata[1:0]) == FPC_OP_HW_RESET) ?
						            S_RST_PULSE : S_FETCH;
					end
				end
				S_FETCH: state <= S_ISSUE;
				S_ISSUE: state <= S_WAIT;
				S_WAIT: begin
					if (cg_done) begin
						if (step != last_step) begin
							step  <= step + 8'h01;
							state <= S_FETCH;
						end else if (op == FPC_OP_ABORT_RESET) begin
							// Flash is back in read mode after the abort reset. [R23]
							st_done <= 1'b1;
							state   <= S_IDLE;
						end else begin
							first_read <= 1'b1;
							state      <= S_RD_ISSUE;
						end
					end
				end
				S_RD_ISSUE: state <= S_RD_WAIT;
				S_RD_WAIT: begin
					if (cg_done) begin
						prev_read  <= cg_rdata;
						poll_word  <= cg_rdata;
						first_read <= 1'b0;
						timer      <= timer + 16'h0001;
						if (!first_read && !toggling) begin
							// Toggling stopped: the flash is in read mode again. [R03] [R20]
							st_done <= 1'b1;
							state   <= S_IDLE;
						end else if (!first_read && seen_abort) begin
							st_abort <= 1'b1; // [R21]
							st_done  <= 1'b1;
							state    <= S_IDLE;
						end else if ((!first_read && seen_tmo) || poll_over) begin
							st_fail <= 1'b1;
							st_done <= 1'b1;
							state   <= S_IDLE;
						end else begin
							state <= S_RD_ISSUE;
						end
					end
				end
				S_RST_PULSE: begin
					// Reset pin held low; any running operation ends. [R07]
					timer <= timer + 16'h0001;
					if (timer == RP_LAST) begin
						timer <= 16'h0000;
						state <= S_RST_WAIT;
					end
				end
				S_RST_WAIT: begin
					timer <= timer + 16'h0001;
					if (timer == RH_LAST) begin
						st_done <= 1'b1;
						state   <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

endmodule

// ==== hdl/fpc_defines.svh ====
// Constants of the flash program controller: register offsets, command codes and timing.
// Assumes a 200 MHz clock and a word-wide flash with a 26-bit word address.
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH

`define FPC_ADDR_W      26
`define FPC_DATA_W      16
`define FPC_BUF_DEPTH   32
`define FPC_BUF_IDX_W   5

// Software register offsets (byte addresses on the command port).
`define FPC_REG_CTRL    8'h00
`define FPC_REG_ADDR    8'h04
`define FPC_REG_DATA    8'h08
`define FPC_REG_COUNT   8'h0C
`define FPC_REG_BUF     8'h10
`define FPC_REG_STATUS  8'h14
`define FPC_REG_POLL    8'h18

// Control register fields.
`define FPC_CTRL_OP_LSB 0
`define FPC_CTRL_OP_MSB 1

// Status register bits.
`define FPC_ST_BUSY     0
`define FPC_ST_DONE     1
`define FPC_ST_ABORT    2
`define FPC_ST_FAIL     3

// Flash unlock addresses and command codes.
`define FPC_UNL1_WORD   26'h0000555
`define FPC_UNL2_WORD   26'h00002AA
`define FPC_UNL1_BYTE   26'h0000AAA
`define FPC_UNL2_BYTE   26'h0000555
`define FPC_CMD_UNL1    16'h00AA
`define FPC_CMD_UNL2    16'h0055
`define FPC_CMD_PROG    16'h00A0
`define FPC_CMD_BUFLOAD 16'h0025
`define FPC_CMD_CONFIRM 16'h0029
`define FPC_CMD_RESET   16'h00F0

// Status bit positions in a word read during an operation.
`define FPC_DQ_POLL     7
`define FPC_DQ_TOGGLE   6
`define FPC_DQ_TIMEOUT  5
`define FPC_DQ_ABORT    1

// Timing in ns and derived cycle counts; least times round up.
`define FPC_CLK_NS      5
`define FPC_T_WP_NS     35
`define FPC_T_WPH_NS    30
`define FPC_T_ACC_NS    90
`define FPC_T_RP_NS     500
`define FPC_T_RH_NS     50
`define FPC_WP_CYC      ((`FPC_T_WP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_WPH_CYC     ((`FPC_T_WPH_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_ACC_CYC     ((`FPC_T_ACC_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_RP_CYC      ((`FPC_T_RP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_RH_CYC      ((`FPC_T_RH_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_SYNC_CYC    2
`define FPC_POLL_MAX    4000

`endif

// ==== hdl/fpc_pkg.sv ====
// Types shared by the flash program controller files.
// Relies on fpc_defines.svh for the address and data widths.
`include "fpc_defines.svh"

package fpc_pkg;

	typedef enum logic [1:0] {
		FPC_OP_SINGLE,
		FPC_OP_BUFFER,
		FPC_OP_ABORT_RESET,
		FPC_OP_HW_RESET
	} fpc_op_t;

	// Drive side of the flash pins.
	typedef struct packed {
		logic [`FPC_ADDR_W-1:0] addr;
		logic [`FPC_DATA_W-1:0] dq_out;
		logic                   dq_oe;
		logic                   chip_select_n;
		logic                   write_strobe_n;
		logic                   output_enable_n;
		logic                   reset_n;
	} fpc_pins_t;

	// One bus cycle to perform on the flash.
	typedef struct packed {
		logic [`FPC_ADDR_W-1:0] addr;
		logic [`FPC_DATA_W-1:0] data;
	} fpc_cycle_t;

endpackage

// ==== hdl/fpc_buf_mem.sv ====
// Word store holding the data for one buffer program pass.
// Written from the command port, read by the sequencer with one cycle of latency.
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_buf_mem #(
	parameter int WIDTH = `FPC_DATA_W,
	parameter int DEPTH = `FPC_BUF_DEPTH,
	parameter int IDX_W = `FPC_BUF_IDX_W
) (
	input  wire logic             clock,
	input  wire logic             wr_en,
	input  wire logic [IDX_W-1:0] wr_idx,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [IDX_W-1:0] rd_idx,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
		rd_data <= mem[rd_idx];
	end

endmodule

// ==== hdl/fpc_cycle_gen.sv ====
// Performs one asynchronous write or read cycle on the flash pins.
// Assumes dq_in comes straight from the pins; it is synchronised here.
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_cycle_gen
	import fpc_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  start,
	input  wire logic                  is_read,
	input  wire fpc_cycle_t            cycle,
	input  wire logic                  hold_reset,
	input  wire logic [`FPC_DATA_W-1:0] dq_in,
	output logic                       done,
	output logic      [`FPC_DATA_W-1:0] rd_data,
	output fpc_pins_t                  pins
);

	typedef enum {CG_IDLE, CG_SETUP, CG_PULSE, CG_HOLD} fpc_cg_state_t;

	fpc_cg_state_t         state;
	logic [7:0]            count;
	logic                  reading;
	logic [`FPC_DATA_W-1:0] dq_meta;
	logic [`FPC_DATA_W-1:0] dq_sync;

	localparam logic [7:0] WP_LAST  = 8'(`FPC_WP_CYC - 1);
	localparam logic [7:0] WPH_LAST = 8'(`FPC_WPH_CYC - 1);
	localparam logic [7:0] RD_LAST  = 8'(`FPC_ACC_CYC + `FPC_SYNC_CYC);

	wire logic pulse_end = (state == CG_PULSE) && (count == (reading ? RD_LAST : WP_LAST));
	wire logic hold_end  = (state == CG_HOLD) && (count == WPH_LAST);

	always_ff @(posedge clock) begin
		dq_meta <= dq_in;
		dq_sync <= dq_meta;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state   <= CG_IDLE;
			count   <= 8'h00;
			reading <= 1'b0;
			done    <= 1'b0;
			rd_data <= '0;
			pins    <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, chip_select_n: 1'b1,
			             write_strobe_n: 1'b1, output_enable_n: 1'b1, reset_n: 1'b1};
		end else begin
			done         <= 1'b0;
			pins.reset_n <= !hold_reset;
			case (state)
				CG_IDLE: begin
					if (start) begin
						// Output enable stays high for a write cycle. [R01]
						state              <= CG_SETUP;
						reading            <= is_read;
						pins.addr          <= cycle.addr;
						pins.dq_out        <= cycle.data;
						pins.dq_oe         <= !is_read;
						pins.chip_select_n <= 1'b0;
					end
				end
				CG_SETUP: begin
					// Address is stable before the strobe falls, so the later falling
					// edge latches it whichever edge the flash takes. [R02]
					state                <= CG_PULSE;
					count                <= 8'h00;
					pins.write_strobe_n  <= reading;
					pins.output_enable_n <= !reading;
				end
				CG_PULSE: begin
					count <= count + 8'h01;
					if (pulse_end) begin
						state                <= CG_HOLD;
						count                <= 8'h00;
						pins.write_strobe_n  <= 1'b1;
						pins.output_enable_n <= 1'b1;
						if (reading) begin
							rd_data <= dq_sync;
						end
					end
				end
				CG_HOLD: begin
					// Data and select stay driven past the rising strobe edge. [R01] [R02]
					count <= count + 8'h01;
					if (hold_end) begin
						state              <= CG_IDLE;
						pins.chip_select_n <= 1'b1;
						pins.dq_oe         <= 1'b0;
						done               <= 1'b1;
					end
				end
				default: state <= CG_IDLE;
			endcase
		end
	end

endmodule

// ==== tb/fpc_host_asserts.sv ====
// Checker of the flash pin sequencing driven by the program controller.
// Bound to fpc_host; it sees the flash pins, the clock and the reset.
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_host_asserts (
	input wire logic                   clock,
	input wire logic                   rst_n,
	input wire logic [`FPC_ADDR_W-1:0] flash_addr,
	input wire logic [`FPC_DATA_W-1:0] flash_dq_out,
	input wire logic                   flash_dq_oe,
	input wire logic                   flash_chip_select_n,
	input wire logic                   flash_write_strobe_n,
	input wire logic                   flash_output_enable_n,
	input wire logic                   flash_reset_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Length of the current reset pulse, so its width can be judged when it ends.
	logic [7:0] rst_low;
	always_ff @(posedge clock) begin
		if (!rst_n || flash_reset_n)
			rst_low <= 8'h00;
		else
			rst_low <= rst_low + 8'h01;
	end
	write_pins_a: assert property (
		$fell(flash_write_strobe_n) |-> !flash_chip_select_n && flash_output_enable_n
			&& flash_dq_oe && $past(!flash_chip_select_n))
		else $error("strobe fell without select, data or idle enable");
	strobe_width_a: assert property (
		$fell(flash_write_strobe_n) |-> !flash_write_strobe_n [*7] ##1 flash_write_strobe_n)
		else $error("write strobe low time wrong");
	strobe_gap_a: assert property (
		$rose(flash_write_strobe_n) |-> flash_write_strobe_n [*6])
		else $error("write strobe high time too short");
	data_hold_a: assert property (
		$rose(flash_write_strobe_n) |-> (!flash_chip_select_n && $stable(flash_dq_out)) [*3])
		else $error("data or select released too early");
	strobe_stable_a: assert property (
		!flash_write_strobe_n |-> $stable(flash_addr) && $stable(flash_dq_out))
		else $error("address or data moved under the strobe");
	read_excl_a: assert property (
		!flash_output_enable_n |-> flash_write_strobe_n && !flash_dq_oe && !flash_chip_select_n)
		else $error("read enable overlaps a write");
	reset_len_a: assert property (
		$rose(flash_reset_n) |-> rst_low == 8'h64)
		else $error("flash reset pulse width wrong");
	reset_quiet_a: assert property (
		!flash_reset_n |-> flash_chip_select_n && flash_write_strobe_n && flash_output_enable_n)
		else $error("bus cycle during flash reset");
	cover property ($rose(flash_reset_n));
	cover property ($fell(flash_output_enable_n));
	cover property ($fell(flash_write_strobe_n) && flash_dq_out == `FPC_CMD_CONFIRM);
endmodule

bind fpc_host fpc_host_asserts i_fpc_host_asserts (
	.clock                 (clock),
	.rst_n                 (rst_n),
	.flash_addr            (flash_addr),
	.flash_dq_out          (flash_dq_out),
	.flash_dq_oe           (flash_dq_oe),
	.flash_chip_select_n   (flash_chip_select_n),
	.flash_write_strobe_n  (flash_write_strobe_n),
	.flash_output_enable_n (flash_output_enable_n),
	.flash_reset_n         (flash_reset_n)
);

// ==== tb/fpc_flash_model.sv ====
// Behavioural model of the word-wide flash on the far side of the controller.
// Assumes select stays low around every strobe; erase and suspend are not modelled.
`timescale 1ns/1ps
`include "fpc_defines.svh"

module fpc_flash_model #(
	parameter int BUSY_READS = 3,
	parameter int SECT_LSB   = 16
) (
	input  wire logic [`FPC_ADDR_W-1:0] addr,
	input  wire logic [`FPC_DATA_W-1:0] dq_wr,
	input  wire logic                   cs_n,
	input  wire logic                   we_n,
	input  wire logic                   oe_n,
	input  wire logic                   reset_n,
	output logic      [`FPC_DATA_W-1:0] dq_rd
);
	typedef enum {FM_IDLE, FM_UNL1, FM_UNL2, FM_PROG, FM_CNT, FM_LOAD, FM_CONF, FM_BUSY} fpc_fm_t;
	fpc_fm_t     st = FM_IDLE;
	logic [15:0] mem [logic [25:0]];
	logic [15:0] bufw [logic [25:0]];
	logic [25:0] lat_addr, sect, last;
	logic [15:0] rd_word = 16'h0000, held = 16'h0000, pdata = 16'h0000;
	logic        tog = 1'b0;
	logic        aborted = 1'b0;
	int          left, busy_left;

	function automatic logic [15:0] word_at(input logic [25:0] a);
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	task automatic prog(input logic [25:0] a, input logic [15:0] d);
		mem[a] = word_at(a) & d;
	endtask
	task automatic fail_op();
		aborted = 1'b1;
		pdata = bufw.exists(last) ? bufw[last] : 16'hFFFF;
		st = FM_IDLE;
	endtask
	task automatic take(input logic [25:0] a, input logic [15:0] d);
		logic bad;
		bad = (bufw.num() != 0 && a[25:5] != last[25:5]) || a[25:SECT_LSB] != sect[25:SECT_LSB];
		case (st)
		FM_IDLE: st = (a == `FPC_UNL1_WORD && d == `FPC_CMD_UNL1) ? FM_UNL1 : FM_IDLE;
		FM_UNL1: st = (a == `FPC_UNL2_WORD && d == `FPC_CMD_UNL2) ? FM_UNL2 : FM_IDLE;
		FM_UNL2: begin
			st = FM_IDLE;
			if (a == `FPC_UNL1_WORD && d == `FPC_CMD_RESET)
				aborted = 1'b0;
			else if (!aborted && a == `FPC_UNL1_WORD && d == `FPC_CMD_PROG)
				st = FM_PROG;
			else if (!aborted && d == `FPC_CMD_BUFLOAD) begin
				sect = a;
				st = FM_CNT;
			end
		end
		FM_PROG: begin
			prog(a, d);
			pdata = word_at(a);
			busy_left = BUSY_READS;
			st = FM_BUSY;
		end
		FM_CNT: begin
			left = int'(d) + 1;
			bufw.delete();
			st = FM_LOAD;
			if (d > 16'h001F)
				fail_op();
		end
		FM_LOAD: begin
			if (bad)
				fail_op();
			else begin
				bufw[a] = d;
				last = a;
				left--;
				if (left == 0)
					st = FM_CONF;
			end
		end
		FM_CONF: begin
			if (d == `FPC_CMD_CONFIRM && a[25:SECT_LSB] == sect[25:SECT_LSB]) begin
				foreach (bufw[k])
					prog(k, bufw[k]);
				pdata = word_at(last);
				busy_left = BUSY_READS;
				st = FM_BUSY;
			end else
				fail_op();
		end
		// While busy every command is ignored; suspend is not modelled.
		default: st = st;
		endcase
	endtask

	always @(negedge we_n)
		if (!cs_n)
			lat_addr = addr;
	always @(posedge we_n)
		if (!cs_n && reset_n)
			take(lat_addr, dq_wr);
	always @(negedge reset_n) begin
		st = FM_IDLE;
		aborted = 1'b0;
	end
	always @(negedge oe_n)
		if (!cs_n)
			rd_word = (st == FM_BUSY || aborted) ?
				{8'h00, ~pdata[7], tog, 4'h0, aborted, 1'b0} : word_at(addr);
	always @(posedge oe_n) begin
		held = rd_word;
		tog = ~tog;
		if (st == FM_BUSY)
			busy_left--;
		if (st == FM_BUSY && busy_left == 0)
			st = FM_IDLE;
	end
	// A released bus shows the inverse of the last word, so stale data never reads as valid.
	assign dq_rd = (!cs_n && !oe_n) ? rd_word : ~held;
endmodule

// ==== tb/tb_fpc_host.sv ====
// Self-checking bench of the flash program controller against a flash model.
// Assumes the controller and the model share the word-wide flash pins.
`timescale 1ns/1ps
`include "fpc_defines.svh"

module tb_fpc_host;
	logic                   clock = 1'b0;
	logic                   rst_n;
	logic [7:0]             reg_addr;
	logic [31:0]            reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [31:0]            reg_rdata, rd_v;
	logic [`FPC_ADDR_W-1:0] flash_addr;
	logic [`FPC_DATA_W-1:0] dq_in, dq_out;
	logic                   dq_oe, cs_n, we_n, oe_n, frst_n;
	int                     fails = 0;
	int                     n_tests = 0;

	fpc_host #(.POLL_MAX(8)) i_fpc_host (
		.clock                 (clock),
		.rst_n                 (rst_n),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_wr                (reg_wr),
		.reg_rd                (reg_rd),
		.reg_rdata             (reg_rdata),
		.flash_addr            (flash_addr),
		.flash_dq_in           (dq_in),
		.flash_dq_out          (dq_out),
		.flash_dq_oe           (dq_oe),
		.flash_chip_select_n   (cs_n),
		.flash_write_strobe_n  (we_n),
		.flash_output_enable_n (oe_n),
		.flash_reset_n         (frst_n)
	);
	fpc_flash_model i_fpc_flash_model (
		.addr    (flash_addr),
		.dq_wr   (dq_out),
		.cs_n    (cs_n),
		.we_n    (we_n),
		.oe_n    (oe_n),
		.reset_n (frst_n),
		.dq_rd   (dq_in)
	);
	initial forever #2.5 clock = ~clock;

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			fails++;
		end
	endtask
	task automatic wrap_up();
		if (fails == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Starts an operation, waits for busy to drop, then compares the masked status.
	task automatic run_op(input logic [1:0] op, input logic [31:0] mask, input logic [31:0] exp);
		int i;
		wr(`FPC_REG_CTRL, {30'h0, op});
		repeat (2) @(posedge clock);
		for (i = 0; i < 20000; i++) begin
			rd(`FPC_REG_STATUS, rd_v);
			if (rd_v[`FPC_ST_BUSY] === 1'b0)
				break;
		end
		if (i == 20000) begin
			fails++;
			wrap_up();
		end
		check("status", rd_v & mask, exp);
	endtask
	task automatic single(input logic [25:0] a, input logic [15:0] d);
		wr(`FPC_REG_ADDR, {6'h00, a});
		wr(`FPC_REG_DATA, {16'h0000, d});
		run_op(2'h0, 32'hF, 32'h2);
	endtask
	task automatic buffer(input logic [25:0] a, input logic [7:0] cnt, input logic [15:0] seed,
			input logic [31:0] mask, input logic [31:0] exp);
		wr(`FPC_REG_ADDR, {6'h00, a});
		wr(`FPC_REG_COUNT, {24'h0, cnt});
		for (int i = 0; i <= int'(cnt); i++)
			wr(`FPC_REG_BUF, {16'h0000, seed ^ i[15:0]});
		run_op(2'h1, mask, exp);
	endtask

	initial begin
		rst_n <= 1'b0;
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rd(`FPC_REG_STATUS, rd_v);
		check("status after reset", rd_v, 32'h0);
		rd(8'h1C, rd_v);
		check("unmapped read", rd_v, 32'h0);
		rd(`FPC_REG_BUF, rd_v);
		check("buffer port read", rd_v, 32'h0);
		single(26'h0001234, 16'h5A0F);
		single(26'h0001234, 16'hF0F0);
		check("cleared bits", i_fpc_flash_model.word_at(26'h0001234), 32'h5000);
		single(26'h3FF0001, 16'h1234);
		check("far word", i_fpc_flash_model.word_at(26'h3FF0001), 32'h1234);
		buffer(26'h0010040, 8'h1F, 16'hA5C3, 32'hF, 32'h2);
		buffer(26'h0010040, 8'h1F, 16'h0F0F, 32'hF, 32'h2);
		for (int i = 0; i < 32; i++)
			check("buffer word", i_fpc_flash_model.word_at(26'h0010040 + 26'(i)),
				{16'h0, (16'hA5C3 ^ i[15:0]) & (16'h0F0F ^ i[15:0])});
		buffer(26'h002001E, 8'h03, 16'h1111, 32'hD, 32'h4);
		rd(`FPC_REG_POLL, rd_v);
		check("abort flags", rd_v & 32'h22, 32'h2);
		check("page abort", i_fpc_flash_model.word_at(26'h002001E), 32'hFFFF);
		run_op(2'h2, 32'hF, 32'h2);
		single(26'h0020000, 16'h00FF);
		check("after abort reset", i_fpc_flash_model.word_at(26'h0020000), 32'h00FF);
		buffer(26'h0030000, 8'h20, 16'h2222, 32'hD, 32'h4);
		check("oversize count", i_fpc_flash_model.word_at(26'h0030000), 32'hFFFF);
		run_op(2'h3, 32'hF, 32'h2);
		single(26'h0030000, 16'h1357);
		check("after reset", i_fpc_flash_model.word_at(26'h0030000), 32'h1357);
		wrap_up();
	end
endmodule
